// ==== rtl/fbs_pkg.sv ====
// Package of constants and carrier types for the flow-through burst SRAM port
`default_nettype none
package fbs_pkg;
  localparam int ADDR_W      = 20;
  localparam int DATA_W      = 32;
  localparam int LANES       = 4;
  localparam int LANE_W      = 8;
  localparam int BURST_LEN   = 4;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] CNT_RST  = 2'h0;
  // Wake-up interval after sleep ends
  localparam int SLEEP_EXIT_TIME_NS = 100;
  localparam int CLK_PERIOD_NS      = 40;
  localparam int SLEEP_EXIT_CYCLES  =
    (SLEEP_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FBS_IDLE  = 2'b00,
    FBS_READ  = 2'b01,
    FBS_WRITE = 2'b10
  } fbs_op_t;

  typedef struct packed {
    logic              chip_select_0_n;
    logic              chip_select_1;
    logic              chip_select_2_n;
    logic              advance_or_load;
    logic              read_not_write;
    logic [LANES-1:0]  byte_write_en_n;
  } fbs_cmd_t;
endpackage : fbs_pkg
`default_nettype wire

// ==== rtl/fbs_burst_step.sv ====
// Two-bit burst address sequencer
`default_nettype none
module fbs_burst_step (
  // Burst position
  input  wire logic [1:0] start_low,
  input  wire logic [1:0] count,
  input  wire logic       burst_order_sel,
  // Address out
  output logic      [1:0] burst_low_addr
);
  always_comb begin
    if (burst_order_sel) begin
      burst_low_addr = start_low ^ count;
    end else begin
      burst_low_addr = 2'(start_low + count);
    end
  end
endmodule : fbs_burst_step
`default_nettype wire

// ==== rtl/fbs_port.sv ====
// Flow-through burst SRAM port with late write, byte lanes and sleep
`default_nettype none
module fbs_port #(
  parameter int ADDR_W = fbs_pkg::ADDR_W,
  parameter int DEPTH  = 1 << fbs_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // Control pins
  input  wire logic                       clock_gate_n,
  input  wire fbs_pkg::fbs_cmd_t          cmd,
  input  wire logic [ADDR_W-1:0]          addr,
  input  wire logic                       output_enable_n,
  input  wire logic                       burst_order_sel,
  input  wire logic                       sleep_request,
  // Data pins
  input  wire logic [fbs_pkg::DATA_W-1:0] dq_in,
  output logic      [fbs_pkg::DATA_W-1:0] dq_out,
  output logic                            dq_oe,
  // Status
  output logic                            asleep
);
  initial begin
    if (ADDR_W < 2 || DEPTH > (1 << ADDR_W) || DEPTH < 4) begin
      $error("fbs_port: unsupported size");
    end
  end

  // ***********************************
  // State
  // ***********************************
  logic [fbs_pkg::DATA_W-1:0] mem [DEPTH];
  fbs_pkg::fbs_op_t           op;
  logic [ADDR_W-1:0]          base;
  logic [1:0]                 count;
  logic [1:0]                 low;
  logic                       wr_pend;
  logic [ADDR_W-1:0]          wr_addr;
  logic [fbs_pkg::LANES-1:0]  wr_be_n;
  logic                       rd_valid;
  logic [fbs_pkg::DATA_W-1:0] rd_data;
  logic [1:0]                 next_count;
  logic                       edge_ok;
  logic                       selected;
  logic [ADDR_W-1:0]          cur_addr;

  fbs_burst_step u_step (
    .start_low      (base[1:0]),
    .count          (next_count),
    .burst_order_sel(burst_order_sel),
    .burst_low_addr (low)
  );

  assign edge_ok  = !clock_gate_n && !sleep_request;
  assign selected = !cmd.chip_select_0_n && cmd.chip_select_1
                    && !cmd.chip_select_2_n;
  // Continuation address: one step past the current burst position
  assign next_count = 2'(count + fbs_pkg::STEP_ONE);
  assign cur_addr   = {base[ADDR_W-1:2], low};

  // ***********************************
  // Command and burst counter
  // ***********************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      op    <= fbs_pkg::FBS_IDLE;
      base  <= '0;
      count <= fbs_pkg::CNT_RST;
    end else if (sleep_request) begin
      op    <= fbs_pkg::FBS_IDLE;
    end else if (edge_ok) begin
      if (!cmd.advance_or_load) begin
        count <= fbs_pkg::CNT_RST;
        if (selected) begin
          base <= addr;
          op   <= cmd.read_not_write ? fbs_pkg::FBS_READ : fbs_pkg::FBS_WRITE;
        end else begin
          op   <= fbs_pkg::FBS_IDLE;
        end
      end else if (op != fbs_pkg::FBS_IDLE) begin
        count <= next_count;
      end
    end
  end

  // ***********************************
  // Late write
  // ***********************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      wr_be_n <= '1;
    end else if (sleep_request) begin
      wr_pend <= 1'b0;
    end else if (edge_ok) begin
      wr_pend <= (!cmd.advance_or_load && selected && !cmd.read_not_write)
                 || (cmd.advance_or_load && op == fbs_pkg::FBS_WRITE);
      wr_addr <= cmd.advance_or_load ? cur_addr : addr;
      wr_be_n <= cmd.byte_write_en_n;
    end
  end

  always_ff @(posedge mclk) begin
    if (edge_ok && wr_pend) begin
      for (int i = 0; i < fbs_pkg::LANES; i++) begin
        if (!wr_be_n[i]) begin
          mem[wr_addr][i*fbs_pkg::LANE_W +: fbs_pkg::LANE_W] <=
            dq_in[i*fbs_pkg::LANE_W +: fbs_pkg::LANE_W];
        end
      end
    end
  end

  // ***********************************
  // Read path and pin drive
  // ***********************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else if (sleep_request) begin
      rd_valid <= 1'b0;
    end else if (edge_ok) begin
      rd_valid <= (!cmd.advance_or_load && selected && cmd.read_not_write)
                  || (cmd.advance_or_load && op == fbs_pkg::FBS_READ);
      rd_data  <= cmd.advance_or_load ? mem[cur_addr] : mem[addr];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else if (sleep_request) begin
      dq_oe  <= 1'b0;
    end else if (edge_ok) begin
      dq_out <= rd_data;
      dq_oe  <= rd_valid && !output_enable_n;
    end else begin
      // Masked edge: data held, drive may only be withdrawn
      dq_oe  <= dq_oe && !output_enable_n;
    end
  end

  // Sleep status follows the request one clock later
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      asleep <= 1'b0;
    end else begin
      asleep <= sleep_request;
    end
  end
endmodule : fbs_port
`default_nettype wire

// ==== verification/fbs_port_checker.sv ====
// Pin timing checker of the burst SRAM port
`default_nettype none
module fbs_port_checker (
  input wire logic mclk, rst_n, clock_gate_n, output_enable_n, sleep_request, dq_oe, asleep,
  input wire fbs_pkg::fbs_cmd_t cmd,
  input wire logic [31:0] dq_out
);
  logic go, sel, ld, mask;
  assign go = !clock_gate_n && !sleep_request;
  assign mask = clock_gate_n && !sleep_request;
  assign sel = !cmd.chip_select_0_n && cmd.chip_select_1 && !cmd.chip_select_2_n;
  assign ld = go && !cmd.advance_or_load;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_rd; ld && sel && cmd.read_not_write; endsequence
  sequence s_wr; ld && sel && !cmd.read_not_write; endsequence
  sequence s_ds; ld && !sel; endsequence
  property p_hold; mask && !output_enable_n |=> $stable(dq_out) && $stable(dq_oe); endproperty
  a_hold: assert property (p_hold) else $error("output moved on masked edge");
  property p_oe_off; !clock_gate_n && output_enable_n |=> !dq_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("driving with oe off");
  property p_rd_on; s_rd ##1 (go && !output_enable_n) |=> dq_oe; endproperty
  a_rd_on: assert property (p_rd_on) else $error("read not driven");
  property p_wr; s_wr ##1 go |=> !dq_oe; endproperty
  a_wr: assert property (p_wr) else $error("driving on write");
  property p_ds; s_ds ##1 go |=> !dq_oe; endproperty
  a_ds: assert property (p_ds) else $error("driving when deselected");
  property p_cont; s_ds ##1 (go && cmd.advance_or_load) ##1 go |=> !dq_oe; endproperty
  a_cont: assert property (p_cont) else $error("driving on deselect advance");
  property p_z_in; sleep_request |=> asleep && !dq_oe; endproperty
  a_z_in: assert property (p_z_in) else $error("not asleep");
  property p_z_out; go |=> !asleep; endproperty
  a_z_out: assert property (p_z_out) else $error("asleep without request");
endmodule : fbs_port_checker
bind fbs_port fbs_port_checker fbs_port_checker_inst (.mclk(mclk), .rst_n(rst_n),
  .clock_gate_n(clock_gate_n), .output_enable_n(output_enable_n),
  .sleep_request(sleep_request), .dq_oe(dq_oe), .asleep(asleep), .cmd(cmd), .dq_out(dq_out));
`default_nettype wire

// ==== verification/fbs_ctrl_model.sv ====
// Controller model that places late write data
`default_nettype none
module fbs_ctrl_model (
  input wire logic mclk, clock_gate_n, sleep_request,
  input wire fbs_pkg::fbs_cmd_t cmd,
  input wire logic [31:0] wd,
  output logic [31:0] dq_in = 32'h0
);
  logic wr = 1'b0;
  logic sel, beat;
  assign sel = !cmd.chip_select_0_n && cmd.chip_select_1 && !cmd.chip_select_2_n;
  assign beat = cmd.advance_or_load ? wr : sel && !cmd.read_not_write;
  always @(posedge mclk) begin
    if (!clock_gate_n && !sleep_request) begin
      if (!cmd.advance_or_load) wr <= sel && !cmd.read_not_write;
      dq_in <= beat ? wd : ~dq_in;
    end
  end
endmodule : fbs_ctrl_model
`default_nettype wire

// ==== verification/fbs_port_tb.sv ====
// Testbench of the flow-through burst SRAM port
`default_nettype none
module fbs_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_n = 1'b0, clock_gate_n = 1'b0, output_enable_n = 1'b0;
  logic burst_order_sel = 1'b0, sleep_request = 1'b0, dq_oe, asleep, gp = 1'b0, rd, wr;
  fbs_pkg::fbs_cmd_t cmd = 9'h15F;
  logic [19:0] addr = 20'h0;
  logic [31:0] wd = 32'h0, dq_in, dq_out;
  logic [31:0] mem [0:31];
  logic [31:0] e [0:2];
  logic [2:0] v = 3'h0;
  logic [4:0] b, x;
  logic [1:0] n;
  int mismatches = 0, n_tests = 0;
  fbs_port fbs_port_inst (.mclk(mclk), .rst_n(rst_n), .clock_gate_n(clock_gate_n), .cmd(cmd),
    .addr(addr), .output_enable_n(output_enable_n), .burst_order_sel(burst_order_sel),
    .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .asleep(asleep));
  fbs_ctrl_model fbs_ctrl_model_inst (.mclk(mclk), .clock_gate_n(clock_gate_n),
    .sleep_request(sleep_request), .cmd(cmd), .wd(wd), .dq_in(dq_in));
  initial forever #20 mclk = ~mclk;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] t);
    n_tests++;
    if (s !== t) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, t, s);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic step(input logic ld, rw, g, input logic [2:0] cs, input logic [4:0] a,
                      input logic [3:0] be, input logic [31:0] d);
    @(posedge mclk);
    if (!gp) begin
      if (v[2]) chk("dq_out", dq_out, e[2]);
      chk("dq_oe", {31'h0, dq_oe}, {31'h0, v[2]});
      v = {v[1:0], 1'b0};
      e[2] = e[1];
      e[1] = e[0];
    end
    if (!g && ld) b = a;
    if (!g && ld) {rd, wr} = {cs == 3'b010 && rw, cs == 3'b010 && !rw};
    if (!g) n = ld ? 2'h0 : n + 2'h1;
    x = {b[4:2], burst_order_sel ? b[1:0] ^ n : b[1:0] + n};
    for (int i = 0; i < 4; i++) if (!g && wr && !be[i]) mem[x][8*i+:8] = d[8*i+:8];
    v[0] = !g && rd;
    e[0] = mem[x];
    gp = g;
    cmd <= {cs, !ld, rw, be};
    addr <= {15'h0, a};
    clock_gate_n <= g;
    wd <= d;
  endtask : step
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    step(1, 0, 0, 3'b010, 5'h11, 4'h0, 32'h10203040);
    for (int i = 1; i < 4; i++) step(0, 1, 0, 3'b101, 5'h0, 4'h0, 32'h10203040 + i);
    step(1, 0, 0, 3'b010, 5'h12, 4'h5, 32'hAABBCCDD);
    burst_order_sel <= 1'b1;
    step(1, 1, 0, 3'b110, 5'h0, 4'hF, 32'h0);
    $display("test write bursts done");
    step(1, 1, 0, 3'b010, 5'h12, 4'hF, 32'h0);
    step(0, 0, 0, 3'b111, 5'h0, 4'hF, 32'h0);
    repeat (2) step(0, 0, 1, 3'b010, 5'h0, 4'hF, 32'h0);
    repeat (3) step(0, 0, 0, 3'b010, 5'h0, 4'hF, 32'h0);
    step(1, 1, 0, 3'b110, 5'h0, 4'hF, 32'h0);
    repeat (3) step(0, 1, 0, 3'b010, 5'h0, 4'hF, 32'h0);
    $display("test burst reads done");
    output_enable_n <= 1'b1;
    sleep_request <= 1'b1;
    repeat (4) @(posedge mclk);
    sleep_request <= 1'b0;
    output_enable_n <= 1'b0;
    burst_order_sel <= 1'b0;
    repeat (fbs_pkg::SLEEP_EXIT_CYCLES) step(1, 1, 0, 3'b110, 5'h0, 4'hF, 32'h0);
    step(1, 1, 0, 3'b010, 5'h11, 4'hF, 32'h0);
    repeat (3) step(0, 1, 0, 3'b110, 5'h0, 4'hF, 32'h0);
    repeat (3) step(1, 1, 0, 3'b110, 5'h0, 4'hF, 32'h0);
    $display("test sleep done");
    test_done;
  end
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
endmodule : fbs_port_tb
`default_nettype wire
